// File: rtl/data_eeprom_access_control.sv
`timescale 1ns/1ps
module data_eeprom_access_control #(
   parameter int WRITE_ONLY_CYCLES  = eeprom_ctrl_pkg::WRITE_ONLY_CYCLES,
   parameter int ERASE_WRITE_CYCLES = eeprom_ctrl_pkg::ERASE_WRITE_CYCLES,
   parameter int PAGE_ERASE_CYCLES  = eeprom_ctrl_pkg::PAGE_ERASE_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        cmd_wr_in,
   input  wire logic        addr_lo_wr_in,
   input  wire logic        addr_hi_wr_in,
   input  wire logic        data_wr_in,
   input  wire logic [7:0]  sfr_wdata_in,
   input  wire logic [2:0]  page_lock_in,
   input  wire logic        code_rd_in,
   input  wire logic [15:0] code_addr_in,
   input  wire logic [7:0]  user_code_data_in,
   output logic      [7:0]  status_out,
   output logic      [7:0]  addr_lo_out,
   output logic      [7:0]  addr_hi_out,
   output logic             attached_out,
   output logic             cpu_stall_out,
   output logic      [7:0]  code_data_out,
   output logic             code_valid_out,
   output logic             code_from_eeprom_out
);
   localparam int PB = eeprom_ctrl_pkg::PAGE_BYTES;
   localparam int AB = eeprom_ctrl_pkg::ARRAY_BYTES;
   localparam int TW = eeprom_ctrl_pkg::TIMER_W;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } state_t;

   state_t                       state_ff;
   eeprom_ctrl_pkg::op_kind_t    op_kind_ff;
   logic [1:0]                   op_page_ff;
   logic [7:0]                   mem_ff [0:AB-1];
   logic [7:0]                   pbuf_ff [0:PB-1];
   logic [PB-1:0]                upd_ff;
   logic                         sv_ff;
   logic                         err_ff;
   logic                         start;
   logic                         done;
   logic [TW-1:0]                op_count;
   eeprom_ctrl_pkg::op_kind_t    nxt_kind;
   logic [1:0]                   nxt_page;
   logic                         nxt_sv;
   logic                         nxt_err;
   logic                         cmd_take;
   logic                         load_cmd;
   logic                         read_hit;

   // commands are only taken while no operation runs
   assign cmd_take = cmd_wr_in && (state_ff == ST_IDLE);
   assign load_cmd = cmd_take
                  && (sfr_wdata_in == eeprom_ctrl_pkg::CMD_LOAD);

   // decode a command: start an operation or flag a refusal
   always_comb begin
      start    = 1'b0;
      nxt_kind = eeprom_ctrl_pkg::OP_ERASE;
      nxt_page = addr_lo_out[7:6];
      nxt_sv   = 1'b0;
      nxt_err  = 1'b0;
      op_count = TW'(PAGE_ERASE_CYCLES);
      case (sfr_wdata_in)
         eeprom_ctrl_pkg::CMD_LOAD,
         eeprom_ctrl_pkg::CMD_ATTACH,
         eeprom_ctrl_pkg::CMD_DETACH: begin
         end
         eeprom_ctrl_pkg::CMD_PAGE_ERASE: begin
            if (!attached_out || addr_lo_out[5:0] != 6'h00
                || addr_lo_out[7:6] == 2'h3) begin
               nxt_err = 1'b1;
            end else if (page_lock_in[addr_lo_out[7:6]]) begin
               nxt_sv = 1'b1;
            end else begin
               start = 1'b1;
            end
         end
         eeprom_ctrl_pkg::CMD_WRITE_ONLY,
         eeprom_ctrl_pkg::CMD_ERASE_WRITE: begin
            if (sfr_wdata_in == eeprom_ctrl_pkg::CMD_WRITE_ONLY) begin
               nxt_kind = eeprom_ctrl_pkg::OP_WRITE_ONLY;
               op_count = TW'(WRITE_ONLY_CYCLES);
            end else begin
               nxt_kind = eeprom_ctrl_pkg::OP_ERASE_WRITE;
               op_count = TW'(ERASE_WRITE_CYCLES);
            end
            if (!attached_out
                || addr_hi_out != eeprom_ctrl_pkg::WINDOW_HIGH
                || addr_lo_out[7:6] == 2'h3) begin
               nxt_err = 1'b1;
            end else if (page_lock_in[addr_lo_out[7:6]]) begin
               nxt_sv = 1'b1;
            end else begin
               start = 1'b1;
            end
         end
         default: nxt_err = 1'b1;
      endcase
      if (!cmd_take) begin
         start   = 1'b0;
         nxt_sv  = 1'b0;
         nxt_err = 1'b0;
      end
   end

   op_timer #(
      .CW (TW)
   ) i_op_timer (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .start_in (start),
      .count_in (op_count),
      .done_out (done)
   );

   // operation state and stall of code execution
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_ff      <= ST_IDLE;
         op_kind_ff    <= eeprom_ctrl_pkg::OP_ERASE;
         op_page_ff    <= 2'h0;
         cpu_stall_out <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  state_ff      <= ST_BUSY;
                  op_kind_ff    <= nxt_kind;
                  op_page_ff    <= nxt_page;
                  cpu_stall_out <= 1'b1;
               end
            end
            ST_BUSY: begin
               if (done) begin
                  state_ff      <= ST_IDLE;
                  cpu_stall_out <= 1'b0;
               end
            end
            default: begin
               state_ff      <= ST_IDLE;
               cpu_stall_out <= 1'b0;
            end
         endcase
      end
   end

   // status bits, reloaded by each command write taken while idle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sv_ff  <= 1'b0;
         err_ff <= 1'b0;
      end else if (cmd_take) begin
         sv_ff  <= nxt_sv;
         err_ff <= nxt_err;
      end
   end

   // readable status image
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         status_out <= eeprom_ctrl_pkg::STATUS_RESET;
      end else begin
         status_out <= eeprom_ctrl_pkg::STATUS_RESET;
         status_out[eeprom_ctrl_pkg::ST_BUSY_BIT] <=
            start || ((state_ff == ST_BUSY) && !done); // busy with accept
         status_out[eeprom_ctrl_pkg::ST_SV_BIT]  <= cmd_take ? nxt_sv : sv_ff;
         status_out[eeprom_ctrl_pkg::ST_ERR_BIT] <=
            cmd_take ? nxt_err : err_ff;
      end
   end

   // attach and detach of the array window
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         attached_out <= 1'b0;
      end else if (cmd_take) begin
         if (sfr_wdata_in == eeprom_ctrl_pkg::CMD_ATTACH) begin
            attached_out <= 1'b1;
         end else if (sfr_wdata_in == eeprom_ctrl_pkg::CMD_DETACH) begin
            attached_out <= 1'b0;
         end
      end
   end

   // address registers with wrap-around increment of the low six bits
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_lo_out <= eeprom_ctrl_pkg::ADDR_RESET;
         addr_hi_out <= eeprom_ctrl_pkg::ADDR_RESET;
      end else begin
         if (addr_lo_wr_in) begin
            addr_lo_out <= sfr_wdata_in;
         end else if (data_wr_in && state_ff == ST_IDLE) begin
            addr_lo_out[5:0] <= addr_lo_out[5:0] + 6'h01;
         end
         if (addr_hi_wr_in) begin
            addr_hi_out <= sfr_wdata_in;
         end
      end
   end

   // page buffer with one update flag per byte
   for (genvar j = 0; j < PB; j++) begin : g_pbuf
      always_ff @(posedge clk_in) begin
         if (!rst_n_in || load_cmd) begin
            pbuf_ff[j] <= 8'h00;
            upd_ff[j]  <= 1'b0;
         end else if (data_wr_in && state_ff == ST_IDLE
                      && addr_lo_out[5:0] == 6'(j)) begin
            pbuf_ff[j] <= sfr_wdata_in;
            upd_ff[j]  <= 1'b1;
         end
      end
   end

   // nonvolatile array, updated when an operation completes
   for (genvar i = 0; i < AB; i++) begin : g_array
      always_ff @(posedge clk_in) begin
         if (done && op_page_ff == 2'(i / PB)) begin
            case (op_kind_ff)
               eeprom_ctrl_pkg::OP_ERASE:
                  mem_ff[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
               eeprom_ctrl_pkg::OP_WRITE_ONLY: begin
                  if (upd_ff[i % PB]) begin
                     mem_ff[i] <= mem_ff[i] & pbuf_ff[i % PB];
                  end
               end
               eeprom_ctrl_pkg::OP_ERASE_WRITE: begin
                  if (upd_ff[i % PB]) begin
                     mem_ff[i] <= pbuf_ff[i % PB];
                  end
               end
               default: mem_ff[i] <= mem_ff[i];
            endcase
         end
      end
   end

   // code space read: window hit only while attached
   assign read_hit = attached_out
                  && code_addr_in[15:8] == eeprom_ctrl_pkg::WINDOW_HIGH
                  && code_addr_in[7:6] != 2'h3;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         code_data_out        <= 8'h00;
         code_valid_out       <= 1'b0;
         code_from_eeprom_out <= 1'b0;
      end else begin
         code_valid_out       <= code_rd_in;
         code_from_eeprom_out <= code_rd_in && read_hit;
         if (code_rd_in) begin
            code_data_out <= read_hit ? mem_ff[code_addr_in[7:0]]
                                      : user_code_data_in;
         end
      end
   end
endmodule : data_eeprom_access_control

// File: rtl/eeprom_ctrl_pkg.sv
package eeprom_ctrl_pkg;
   // array geometry
   localparam int          PAGE_BYTES     = 64;
   localparam int          NUM_PAGES      = 3;
   localparam int          ARRAY_BYTES    = PAGE_BYTES * NUM_PAGES;
   localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
   // attach window in code space
   localparam logic [7:0]  WINDOW_HIGH    = 8'hFF;
   localparam logic [15:0] PAGE0_BASE     = 16'hFF00;
   localparam logic [15:0] PAGE1_BASE     = 16'hFF40;
   localparam logic [15:0] PAGE2_BASE     = 16'hFF80;
   // command codes
   localparam logic [7:0]  CMD_LOAD       = 8'h00;
   localparam logic [7:0]  CMD_ATTACH     = 8'h09;
   localparam logic [7:0]  CMD_DETACH     = 8'h0A;
   localparam logic [7:0]  CMD_PAGE_ERASE = 8'h33;
   localparam logic [7:0]  CMD_WRITE_ONLY = 8'h48;
   localparam logic [7:0]  CMD_ERASE_WRITE = 8'h68;
   // status bit positions
   localparam int          ST_BUSY_BIT    = 7;
   localparam int          ST_SV_BIT      = 1;
   localparam int          ST_ERR_BIT     = 0;
   // reset values
   localparam logic [7:0]  ADDR_RESET     = 8'h00;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   // operation times and derived cycle counts
   localparam int          CLK_FREQ_HZ       = 50000000;
   localparam int          WRITE_ONLY_MS     = 2;
   localparam int          ERASE_WRITE_MS    = 4;
   localparam int          PAGE_ERASE_MS     = 6;
   localparam int          WRITE_ONLY_CYCLES  =
      WRITE_ONLY_MS * (CLK_FREQ_HZ / 1000);
   localparam int          ERASE_WRITE_CYCLES =
      ERASE_WRITE_MS * (CLK_FREQ_HZ / 1000);
   localparam int          PAGE_ERASE_CYCLES  =
      PAGE_ERASE_MS * (CLK_FREQ_HZ / 1000);
   localparam int          TIMER_W           = 20;
   // kind of running operation
   typedef enum logic [1:0] {
      OP_ERASE       = 2'h0,
      OP_WRITE_ONLY  = 2'h1,
      OP_ERASE_WRITE = 2'h2
   } op_kind_t;
endpackage : eeprom_ctrl_pkg

// File: rtl/op_timer.sv
`timescale 1ns/1ps
module op_timer #(
   parameter int CW = 20
) (
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          start_in,
   input  wire logic [CW-1:0] count_in,
   output logic               done_out
);
   logic [CW-1:0] remain_ff;
   logic          run_ff;

   // count down the operation time, pulse done on the last cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         remain_ff <= '0;
         run_ff    <= 1'b0;
         done_out  <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            remain_ff <= count_in - CW'(1);
            run_ff    <= 1'b1;
         end else if (run_ff) begin
            if (remain_ff <= CW'(1)) begin
               run_ff   <= 1'b0;
               done_out <= 1'b1;
            end
            remain_ff <= remain_ff - CW'(1);
         end
      end
   end
endmodule : op_timer

// File: tb/eeprom_ctrl_props.sv
`timescale 1ns/1ps
module eeprom_ctrl_props #(
   parameter int WRITE_ONLY_CYCLES  = 10,
   parameter int ERASE_WRITE_CYCLES = 20,
   parameter int PAGE_ERASE_CYCLES  = 30
) (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        cmd_wr_in,
   input wire logic        addr_lo_wr_in,
   input wire logic        addr_hi_wr_in,
   input wire logic        data_wr_in,
   input wire logic [7:0]  sfr_wdata_in,
   input wire logic [2:0]  page_lock_in,
   input wire logic        code_rd_in,
   input wire logic [15:0] code_addr_in,
   input wire logic [7:0]  user_code_data_in,
   input wire logic [7:0]  status_out,
   input wire logic [7:0]  addr_lo_out,
   input wire logic [7:0]  addr_hi_out,
   input wire logic        attached_out,
   input wire logic        cpu_stall_out,
   input wire logic [7:0]  code_data_out,
   input wire logic        code_valid_out,
   input wire logic        code_from_eeprom_out
);
   // command write that the controller takes
   logic go;
   // length of the running stall and the time its operation should take
   int   stall_len_ff;
   int   stall_exp_ff;
   assign go = cmd_wr_in && !status_out[7];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // count stalled cycles, restart whenever the stall is low
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !cpu_stall_out) begin
         stall_len_ff <= 0;
      end else begin
         stall_len_ff <= stall_len_ff + 1;
      end
   end

   // remember the operation time that each accepted command asks for
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         stall_exp_ff <= 0;
      end else if (go && sfr_wdata_in == 8'h33) begin
         stall_exp_ff <= PAGE_ERASE_CYCLES;
      end else if (go && sfr_wdata_in == 8'h48) begin
         stall_exp_ff <= WRITE_ONLY_CYCLES;
      end else if (go && sfr_wdata_in == 8'h68) begin
         stall_exp_ff <= ERASE_WRITE_CYCLES;
      end
   end

   AST_ATTACH: assert property (
      go && sfr_wdata_in == 8'h09 |=> attached_out)
      else $error("attach command ignored");
   AST_DETACH: assert property (
      go && sfr_wdata_in == 8'h0A |=> !attached_out)
      else $error("detach command ignored");
   AST_CLEAR: assert property (
      go && sfr_wdata_in inside {8'h00, 8'h09, 8'h0A}
      |=> status_out[1:0] == 2'h0) else $error("status not cleared");
   AST_REFUSE: assert property (
      go && sfr_wdata_in == 8'h33 && !attached_out
      && page_lock_in == 3'h0 |=> status_out == 8'h01)
      else $error("detached erase not refused");
   AST_ERASE_TIME: assert property (
      go && sfr_wdata_in == 8'h33 && attached_out
      && addr_lo_out == 8'h40 && !page_lock_in[1]
      |=> cpu_stall_out [*8] ##[20:40] !cpu_stall_out)
      else $error("erase stall length wrong");
   AST_STALL_LEN: assert property (
      $fell(cpu_stall_out) |-> stall_len_ff == stall_exp_ff)
      else $error("operation stall length wrong");
   AST_STATUS_PAD: assert property (status_out[6:2] == 5'h00)
      else $error("unused status bits set");
   AST_EE_READ: assert property (
      code_rd_in && attached_out && !cmd_wr_in
      && code_addr_in inside {[16'hFF00:16'hFFBF]}
      |=> code_valid_out && code_from_eeprom_out)
      else $error("window read not served by array");
   AST_USER_READ: assert property (
      code_rd_in && !attached_out && !cmd_wr_in
      |=> code_valid_out && !code_from_eeprom_out
      && code_data_out == $past(user_code_data_in))
      else $error("detached read not served by user code");
   AST_INCR: assert property (
      data_wr_in && !status_out[7] && !addr_lo_wr_in
      |=> addr_lo_out == {$past(addr_lo_out[7:6]),
                          $past(addr_lo_out[5:0]) + 6'h01})
      else $error("address increment wrong");
   AST_BUSY_REFUSE: assert property (status_out[7] && cmd_wr_in
      |=> $stable(attached_out)) else $error("command taken while busy");
endmodule : eeprom_ctrl_props

bind data_eeprom_access_control eeprom_ctrl_props #(
   .WRITE_ONLY_CYCLES(WRITE_ONLY_CYCLES),
   .ERASE_WRITE_CYCLES(ERASE_WRITE_CYCLES),
   .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES)
) i_eeprom_ctrl_props (.*);

// File: tb/user_code_mem_model.sv
`timescale 1ns/1ps
module user_code_mem_model (
   input  wire logic [15:0] code_addr_in,
   output logic      [7:0]  code_byte_out
);
   // user code bytes differ per address so a wrong source is seen
   assign code_byte_out = code_addr_in[7:0] ^ code_addr_in[15:8] ^ 8'h5A;
endmodule : user_code_mem_model

// File: tb/test_data_eeprom_access_control.sv
`timescale 1ns/1ps
module test_data_eeprom_access_control;
   logic        clk_in, rst_n_in, cmd_wr_in, addr_lo_wr_in, addr_hi_wr_in;
   logic        data_wr_in, code_rd_in, attached_out, cpu_stall_out;
   logic        code_valid_out, code_from_eeprom_out;
   logic [7:0]  sfr_wdata_in, user_code_data_in, status_out, addr_lo_out;
   logic [7:0]  addr_hi_out, code_data_out;
   logic [2:0]  page_lock_in;
   logic [15:0] code_addr_in;
   int          error_cnt, samples_checked;

   data_eeprom_access_control #(.WRITE_ONLY_CYCLES(10),
      .ERASE_WRITE_CYCLES(20), .PAGE_ERASE_CYCLES(30))
      i_data_eeprom_access_control (.*);
   user_code_mem_model i_user_code_mem_model (.code_addr_in(code_addr_in),
      .code_byte_out(user_code_data_in));

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] ucode(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : ucode

   // one-cycle strobe: 0 command, 1 addr low, 2 addr high, 3 data
   task automatic wr(input int sel, input logic [7:0] v);
      @(posedge clk_in);
      sfr_wdata_in <= v;
      {cmd_wr_in, addr_lo_wr_in, addr_hi_wr_in, data_wr_in} <=
         {sel == 0, sel == 1, sel == 2, sel == 3};
      @(posedge clk_in);
      {cmd_wr_in, addr_lo_wr_in, addr_hi_wr_in, data_wr_in} <= 4'h0;
      #1;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic ee);
      @(posedge clk_in);
      code_rd_in <= 1'b1;
      code_addr_in <= a;
      @(posedge clk_in);
      code_rd_in <= 1'b0;
      #1;
      chk({7'h00, code_valid_out}, 8'h01);
      chk({7'h00, code_from_eeprom_out}, {7'h00, ee});
      chk(code_data_out, e);
   endtask : rd

   // start an operation, poke it while busy, time it to the end
   task automatic op(input logic [7:0] c, input int p);
      int n;
      wr(0, c);
      chk(status_out, 8'h80);
      chk({7'h00, cpu_stall_out}, 8'h01);
      wr(0, 8'h0A);
      chk({7'h00, attached_out}, 8'h01);
      for (n = 1; n < 100 && status_out[7] !== 1'b0; n++) begin
         @(posedge clk_in);
         #1;
      end
      if (n >= 100) begin
         error_cnt++;
         end_of_test();
      end
      chk(8'(n inside {[p-4:p+2]}), 8'h01);
      chk({7'h00, cpu_stall_out}, 8'h00);
   endtask : op

   task automatic t_detached();
      chk(status_out, 8'h00);
      chk({7'h00, attached_out}, 8'h00);
      rd(16'hFF00, ucode(16'hFF00), 1'b0);
      wr(1, 8'h40);
      wr(0, 8'h33);
      chk(status_out, 8'h01);
      wr(0, 8'h09);
      chk({7'h00, attached_out}, 8'h01);
      chk(status_out, 8'h00);
      rd(16'hFFC0, ucode(16'hFFC0), 1'b0);
      $display("detached and attach test done");
   endtask : t_detached

   task automatic t_erase();
      wr(1, 8'h40);
      op(8'h33, 30);
      for (int i = 0; i < 64; i++) rd(16'hFF40 + 16'(i), 8'hFF, 1'b1);
      rd(16'hFF7F, 8'hFF, 1'b1);
      $display("page erase test done");
   endtask : t_erase

   task automatic t_write();
      wr(2, 8'hFF);
      chk(addr_hi_out, 8'hFF);
      wr(0, 8'h00);
      wr(1, 8'h7F);
      wr(3, 8'hA5);
      chk(addr_lo_out, 8'h40);
      wr(3, 8'h3C);
      chk(addr_lo_out, 8'h41);
      op(8'h68, 20);
      rd(16'hFF7F, 8'hA5, 1'b1);
      rd(16'hFF40, 8'h3C, 1'b1);
      rd(16'hFF41, 8'hFF, 1'b1);
      wr(0, 8'h00);
      wr(1, 8'h7F);
      wr(3, 8'h0F);
      op(8'h48, 10);
      rd(16'hFF7F, 8'h05, 1'b1);
      rd(16'hFF40, 8'h3C, 1'b1);
      $display("byte write test done");
   endtask : t_write

   task automatic t_lock();
      @(posedge clk_in);
      page_lock_in <= 3'h2;
      wr(1, 8'h40);
      wr(0, 8'h33);
      chk(status_out, 8'h02);
      @(posedge clk_in);
      page_lock_in <= 3'h0;
      wr(0, 8'h55);
      chk(status_out, 8'h01);
      wr(0, 8'h0A);
      chk({7'h00, attached_out}, 8'h00);
      rd(16'hFF40, ucode(16'hFF40), 1'b0);
      $display("lock and detach test done");
   endtask : t_lock

   // reset, then each scenario in turn
   initial begin
      {rst_n_in, cmd_wr_in, addr_lo_wr_in, addr_hi_wr_in} = 4'h0;
      {data_wr_in, code_rd_in, sfr_wdata_in, page_lock_in} = 13'h0000;
      code_addr_in = 16'h0000;
      error_cnt = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1;
      t_detached();
      t_erase();
      t_write();
      t_lock();
      end_of_test();
   end
endmodule : test_data_eeprom_access_control
